// ### bms_host_model.sv
// Host side model of the two-wire bus lines
`default_nettype none
module bms_host_model
(
  input  wire logic run,
  input  wire logic park_low,
  input  wire logic spike,
  input  wire logic dev_oe_n,
  output var  logic scl,
  output var  logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_lvl = 1'b1;
  logic host_sda = 1'b1;

  // Clock toggles only in frames, lines held low only on request
  always
  begin
    #80;
    clk_lvl = run ? ~clk_lvl : !park_low;
    host_sda = run ? (clk_lvl ? host_sda : ~host_sda) : !park_low;
  end

  // Pulled-up data line, each party only pulls low; the spike input inverts the clock line
  assign scl = clk_lvl ^ spike;
  assign sda = host_sda & dev_oe_n;
endmodule
`default_nettype wire

// ### bms_line_filter.sv
// Two-stage synchroniser and spike filter for one bus line
`default_nettype none
module bms_line_filter
  import bms_pkg::*;
#(
  parameter int SPIKE_CYCLES = SPIKE_CYC
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic line_raw,
  output var  logic line_filt
);
  logic             sync1_reg;
  logic             sync2_reg;
  logic [CNT_W-1:0] stable_cnt_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= line_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // A new level must outlast the longest spike to be taken
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stable_cnt_reg <= '0;
      line_filt      <= 1'b0;
    end
    else if (sync2_reg == line_filt)
    begin
      stable_cnt_reg <= '0;
    end
    else if (stable_cnt_reg >= CNT_W'(SPIKE_CYCLES))
    begin
      stable_cnt_reg <= '0;
      line_filt      <= sync2_reg;
    end
    else
    begin
      stable_cnt_reg <= stable_cnt_reg + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ### bms_pkg.sv
// Shared constants and types of the battery monitor sequencer
`default_nettype none
package bms_pkg;
  localparam longint CLK_PERIOD_PS    = 64'd20_000;
  localparam longint SPIKE_MAX_PS     = 64'd50_000;
  localparam longint SLEEP_MIN_PS     = 64'd1_500_000_000_000;
  localparam longint CONV_TIME_PS     = 64'd220_000_000_000;
  localparam longint CURR_PERIOD_PS   = 64'd878_000_000_000;
  localparam longint PRECHARGE_MIN_PS = 64'd13_300_000_000;

  // Least times round up, whole periods round down
  localparam int SPIKE_CYC     = int'((SPIKE_MAX_PS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
  localparam int SLEEP_CYC     = int'((SLEEP_MIN_PS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
  localparam int CONV_CYC      = int'(CONV_TIME_PS / CLK_PERIOD_PS);
  localparam int CURR_CYC      = int'(CURR_PERIOD_PS / CLK_PERIOD_PS);
  localparam int PRECHARGE_CYC = int'((PRECHARGE_MIN_PS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);

  localparam int CNT_W  = 32;
  localparam int DATA_W = 16;

  localparam logic [DATA_W-1:0] MEAS_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] ACCUM_MAX   = 16'hFFFF;
  localparam logic [DATA_W-1:0] ACCUM_MIN   = 16'h0000;

  typedef enum logic [1:0] {
    CH_VIN  = 2'b00,
    CH_AUX_INPUT_ZERO = 2'b01,
    CH_AUX_INPUT_ONE = 2'b10
  } bms_chan_type;

  typedef enum logic {
    MODE_ACTIVE = 1'b0,
    MODE_SLEEP  = 1'b1
  } bms_mode_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } bms_bus_type;

  typedef struct packed {
    logic [DATA_W-1:0] battery;
    logic [DATA_W-1:0] aux_zero;
    logic [DATA_W-1:0] aux_one;
  } bms_volt_type;
endpackage
`default_nettype wire

// ### bms_seq.sv
// Measurement and power sequencer of the battery monitor
`default_nettype none
module bms_seq
  import bms_pkg::*;
#(
  parameter int SLEEP_CYCLES     = SLEEP_CYC,
  parameter int CONV_CYCLES      = CONV_CYC,
  parameter int CURR_CYCLES      = CURR_CYC,
  parameter int PRECHARGE_CYCLES = PRECHARGE_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  input  wire logic                sda_pull_req,
  input  wire logic                sleep_permit,
  input  wire logic                divider_supply_disable,
  input  wire logic [DATA_W-1:0]   volt_adc_data,
  input  wire logic [DATA_W-1:0]   curr_adc_data,
  output var  logic                sda_out,
  output var  logic                sda_oe_n,
  output var  logic                divider_supply_out,
  output var  logic [1:0]          volt_chan_sel,
  output var  logic                volt_ref_ratiometric,
  output var  logic                volt_conv_run,
  output var  logic                curr_conv_run,
  output var  logic                sleep_state,
  output var  bms_bus_type         bus_filt,
  output var  bms_volt_type        volt_meas,
  output var  logic [DATA_W-1:0]   current_reg,
  output var  logic [DATA_W-1:0]   charge_accumulator
);
  bms_bus_type      bus_raw;
  bms_bus_type      bus_clean;
  bms_mode_type     mode_reg;
  bms_chan_type     chan_reg;
  bms_chan_type     chan_next;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic [CNT_W-1:0] curr_cnt_reg;
  logic             any_high;
  logic             active;
  logic             conv_done;
  logic             curr_done;
  logic             supply_next;
  logic signed [DATA_W+1:0] accum_sum;

  assign bus_raw.scl = scl_in;
  assign bus_raw.sda = sda_in;

  // One filter per bus line
  genvar gi;
  generate
    for (gi = 0; gi < $bits(bms_bus_type); gi++)
    begin : g_filt
      bms_line_filter #(
        .SPIKE_CYCLES (SPIKE_CYC)
      ) u_filt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .line_raw  (bus_raw[gi]),
        .line_filt (bus_clean[gi])
      );
    end
  endgenerate

  assign any_high  = bus_clean.scl | bus_clean.sda;
  assign active    = (mode_reg == MODE_ACTIVE);
  assign conv_done = active && (conv_cnt_reg >= CNT_W'(CONV_CYCLES - 1));
  assign curr_done = active && (curr_cnt_reg >= CNT_W'(CURR_CYCLES - 1));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_filt <= '0;
    end
    else
    begin
      bus_filt <= bus_clean;
    end
  end

  // Data line is open drain; the clock line is never driven
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~sda_pull_req;
    end
  end

  // Bus low timer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      low_cnt_reg <= '0;
    end
    else if (any_high || !sleep_permit || !active)
    begin
      low_cnt_reg <= '0;
    end
    else if (low_cnt_reg < CNT_W'(SLEEP_CYCLES))
    begin
      low_cnt_reg <= low_cnt_reg + CNT_W'(1);
    end
  end

  // Power mode
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= MODE_ACTIVE;
    end
    else
    begin
      unique case (mode_reg)
        MODE_ACTIVE:
        begin
          if (sleep_permit && !any_high && (low_cnt_reg >= CNT_W'(SLEEP_CYCLES - 1)))
          begin
            mode_reg <= MODE_SLEEP;
          end
        end
        MODE_SLEEP:
        begin
          if (any_high)
          begin
            mode_reg <= MODE_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sleep_state <= 1'b0;
    end
    else
    begin
      sleep_state <= (mode_reg == MODE_SLEEP);
    end
  end

  // Voltage slot timer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      conv_cnt_reg <= '0;
    end
    else if (!active || conv_done)
    begin
      conv_cnt_reg <= '0;
    end
    else
    begin
      conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
    end
  end

  always_comb
  begin
    unique case (chan_reg)
      CH_VIN:  chan_next = CH_AUX_INPUT_ZERO;
      CH_AUX_INPUT_ZERO: chan_next = CH_AUX_INPUT_ONE;
      CH_AUX_INPUT_ONE: chan_next = CH_VIN;
      default: chan_next = CH_VIN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chan_reg <= CH_VIN;
    end
    else if (!active)
    begin
      chan_reg <= CH_VIN;
    end
    else if (conv_done)
    begin
      chan_reg <= chan_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      volt_chan_sel        <= CH_VIN;
      volt_ref_ratiometric <= 1'b0;
      volt_conv_run        <= 1'b0;
    end
    else
    begin
      volt_chan_sel        <= chan_reg;
      volt_ref_ratiometric <= (chan_reg != CH_VIN);
      volt_conv_run        <= active;
    end
  end

  // Divider supply: precharge before aux zero, off after aux one
  always_comb
  begin
    supply_next = 1'b0;
    if (active && !divider_supply_disable)
    begin
      unique case (chan_reg)
        CH_VIN:  supply_next = (conv_cnt_reg >= CNT_W'(CONV_CYCLES - PRECHARGE_CYCLES));
        CH_AUX_INPUT_ZERO: supply_next = 1'b1;
        CH_AUX_INPUT_ONE: supply_next = 1'b1;
        default: supply_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      divider_supply_out <= 1'b0;
    end
    else
    begin
      divider_supply_out <= supply_next;
    end
  end

  // Voltage results
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      volt_meas <= '{MEAS_RESET, MEAS_RESET, MEAS_RESET};
    end
    else if (conv_done)
    begin
      unique case (chan_reg)
        CH_VIN:  volt_meas.battery  <= volt_adc_data;
        CH_AUX_INPUT_ZERO: volt_meas.aux_zero <= volt_adc_data;
        CH_AUX_INPUT_ONE: volt_meas.aux_one  <= volt_adc_data;
        default: volt_meas.battery  <= volt_meas.battery;
      endcase
    end
  end

  // Current averaging period, independent of the voltage slots
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      curr_cnt_reg  <= '0;
      curr_conv_run <= 1'b0;
    end
    else
    begin
      curr_conv_run <= active;
      if (!active || curr_done)
      begin
        curr_cnt_reg <= '0;
      end
      else
      begin
        curr_cnt_reg <= curr_cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      current_reg <= MEAS_RESET;
    end
    else if (curr_done)
    begin
      current_reg <= curr_adc_data;
    end
  end

  // Accumulate with clamping at both ends
  assign accum_sum = $signed({2'b00, charge_accumulator})
                   + $signed({{2{curr_adc_data[DATA_W-1]}}, curr_adc_data});

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      charge_accumulator <= MEAS_RESET;
    end
    else if (curr_done)
    begin
      if (accum_sum < 0)
      begin
        charge_accumulator <= ACCUM_MIN;
      end
      else if (accum_sum > $signed({2'b00, ACCUM_MAX}))
      begin
        charge_accumulator <= ACCUM_MAX;
      end
      else
      begin
        charge_accumulator <= accum_sum[DATA_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### bms_seq_bench.sv
// Self-checking bench of the battery monitor sequencer
`default_nettype none
module bms_seq_bench
  import bms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLP = 200;
  localparam int CNV = 50;
  localparam int CUR = 70;
  localparam int PRE = 10;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        park_low = 1'b0;
  logic        spike = 1'b0;
  logic        sda_pull_req = 1'b0;
  logic        sleep_permit = 1'b0;
  logic        dis = 1'b0;
  logic [15:0] vdat = '0;
  logic [15:0] cdat = '0;
  logic [15:0] lf = 16'h0046;
  logic [15:0] snap;
  logic [15:0] cur;
  logic [15:0] acc;
  logic [1:0]  sel;
  logic [1:0]  sel_q;
  logic [15:0] vd_q1;
  logic [15:0] vd_q2;
  logic        low_seen;
  bms_volt_type vm;
  logic        scl, sda, sda_out, sda_oe_n, sup, vref, vrun, crun, slp, dis_q, mix;
  bms_bus_type bus;
  int          n_mismatch = 0;
  int          checks = 0;
  int          slot = 0;
  int          on_cnt = 0;

  bms_seq #(.SLEEP_CYCLES(SLP), .CONV_CYCLES(CNV), .CURR_CYCLES(CUR), .PRECHARGE_CYCLES(PRE)) u_bms_seq (
    .sys_clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_pull_req, .sleep_permit, .divider_supply_disable(dis),
    .volt_adc_data(vdat), .curr_adc_data(cdat), .sda_out, .sda_oe_n, .divider_supply_out(sup),
    .volt_chan_sel(sel), .volt_ref_ratiometric(vref), .volt_conv_run(vrun), .curr_conv_run(crun),
    .sleep_state(slp), .bus_filt(bus), .volt_meas(vm), .current_reg(cur), .charge_accumulator(acc));
  bms_host_model u_bms_host_model (.run, .park_low, .spike, .dev_oe_n(sda_oe_n), .scl, .sda);

  always #10 sys_clk = ~sys_clk;

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] acc_add(input logic [15:0] a, input logic [15:0] d);
    logic [17:0] s;
    s = {2'b00, a} + {{2{d[15]}}, d};
    return s[17] ? 16'h0000 : (s[16] ? 16'hFFFF : s[15:0]);
  endfunction

  function automatic logic [15:0] volt_of(input bms_volt_type v, input logic [1:0] c);
    return (c == 2'd0) ? v.battery : ((c == 2'd1) ? v.aux_zero : v.aux_one);
  endfunction

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(negedge sys_clk)
  begin
    lf <= nx(lf);
    vdat <= lf;
    sda_pull_req <= run & lf[3];
  end

  // Slot lengths and supply-on time per clean pass
  always @(posedge sys_clk)
  begin
    sel_q <= sel;
    dis_q <= dis;
    vd_q1 <= vdat;
    vd_q2 <= vd_q1;
    slot <= (sel != sel_q) ? 1 : slot + 1;
    on_cnt <= (sel != sel_q && sel == 2'd0) ? int'(sup) : on_cnt + int'(sup);
    mix <= ((sel != sel_q && sel == 2'd0) ? 1'b0 : mix) | slp | (dis != dis_q) | !rst_n;
    if (rst_n && slot == 5)
      cmp("ratiometric", 16'(sel != 2'd0), 16'(vref));
    if (rst_n && !mix && sel != sel_q)
    begin
      cmp("slot", 16'(CNV), 16'(slot));
      cmp("voltage", vd_q2, volt_of(vm, sel_q));
      if (sel == 2'd0)
        cmp("supply on", dis ? 16'h0000 : 16'(PRE + 2 * CNV), 16'(on_cnt));
    end
  end

  initial
  begin
    cyc(6);
    rst_n = 1'b1;
    cmp("data enable", 16'h0001, 16'(sda_oe_n));
    run = 1'b1;
    cdat = 16'h7FFF;
    cyc(3 * CUR + 3);
    cmp("current", 16'h7FFF, cur);
    cmp("acc max", 16'hFFFF, acc);
    cdat = 16'h8000;
    cyc(2 * CUR);
    cmp("acc min", 16'h0000, acc);
    cdat = lf & 16'h00FF | 16'h0001;
    dis = 1'b1;
    cyc(CUR);
    cmp("acc step", cdat, acc);
    cyc(200);
    dis = 1'b0;
    run = 1'b0;
    cyc(20);
    for (int w = SPIKE_CYC; w <= 10; w += 10 - SPIKE_CYC)
    begin
      low_seen = 1'b0;
      spike = 1'b1;
      for (int c = 0; c < w + 12; c++)
      begin
        if (c == w)
          spike = 1'b0;
        cyc(1);
        low_seen = low_seen | !bus.scl;
      end
      cmp("filtered clock", 16'(w > SPIKE_CYC), 16'(low_seen));
    end
    park_low = 1'b1;
    cyc(SLP + 50);
    cmp("sleep refused", 16'h0000, 16'(slp));
    sleep_permit = 1'b1;
    cyc(SLP - 10);
    cmp("sleep early", 16'h0000, 16'(slp));
    cyc(20);
    cmp("sleep", 16'h0001, 16'(slp));
    snap = acc;
    cyc(2 * CUR);
    cmp("acc held", snap, acc);
    cmp("paused", 16'h0000, 16'({vrun, crun}));
    cmp("lines low", 16'h0000, 16'(bus));
    park_low = 1'b0;
    for (int i = 0; i < 20 && slp !== 1'b0; i++)
      cyc(1);
    cmp("woken", 16'h0000, 16'(slp));
    cmp("lines high", 16'h0003, 16'(bus));
    cmp("first channel", 16'h0000, 16'(sel));
    cyc(CUR - 4);
    cmp("acc fresh period", snap, acc);
    cyc(6);
    cmp("acc after wake", acc_add(snap, cdat), acc);
    end_of_test();
  end

  initial
  begin
    #(20 * 5000);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ### bms_seq_checker.sv
// Bus, sequencing and sleep assertions of the sequencer
`default_nettype none
module bms_seq_checker
  import bms_pkg::*;
#(
  parameter int SLEEP_CYCLES = 200
)
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        sda_pull_req,
  input wire logic        sleep_permit,
  input wire logic        divider_supply_disable,
  input wire logic [15:0] curr_adc_data,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        divider_supply_out,
  input wire logic [1:0]  volt_chan_sel,
  input wire logic        curr_conv_run,
  input wire logic        sleep_state,
  input wire bms_bus_type bus_filt,
  input wire logic [15:0] current_reg,
  input wire logic [15:0] charge_accumulator
);
  timeunit 1ns;
  timeprecision 1ps;
  int          low_cnt;
  logic [17:0] acc_sum;
  logic [15:0] acc_exp;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Cycles of permitted low bus while awake
  always_ff @(posedge sys_clk)
    if (!rst_n || sleep_state || !sleep_permit || bus_filt != 2'b00)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;

  assign acc_sum = {2'b00, charge_accumulator} + {{2{curr_adc_data[15]}}, curr_adc_data};
  assign acc_exp = acc_sum[17] ? ACCUM_MIN : (acc_sum[16] ? ACCUM_MAX : acc_sum[15:0]);

  chk_data_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_oe_follow: assert property ($past(rst_n) |-> sda_oe_n == !$past(sda_pull_req))
    else $error("data pull not following request");
  chk_chan_order: assert property (volt_chan_sel != 2'd3 && (!$changed(volt_chan_sel)
    || volt_chan_sel == 2'd0 || volt_chan_sel == $past(volt_chan_sel) + 2'd1))
    else $error("channel out of order");
  chk_supply_gap: assert property (volt_chan_sel == 2'd2 ##1 volt_chan_sel == 2'd0 |=> !divider_supply_out [*8])
    else $error("divider supply on after aux inputs");
  chk_supply_dis: assert property (divider_supply_disable [*2] |-> !divider_supply_out)
    else $error("divider supply on while disabled");
  chk_sleep_late: assert property (low_cnt < SLEEP_CYCLES + 4)
    else $error("sleep entry too late");
  chk_sleep_early: assert property ($rose(sleep_state) |-> $past(low_cnt) >= SLEEP_CYCLES - 3)
    else $error("sleep entry too early");
  chk_wake_fast: assert property (sleep_state && bus_filt != 2'b00 |-> ##[1:2] !sleep_state)
    else $error("wake too slow");
  chk_sleep_hold: assert property (sleep_state && $past(sleep_state)
    |-> $stable(charge_accumulator) && !curr_conv_run)
    else $error("activity during sleep");
  chk_curr_load: assert property ($changed(current_reg) |-> current_reg == $past(curr_adc_data))
    else $error("current value not from converter");
  chk_acc_sum: assert property ($changed(charge_accumulator) |-> charge_accumulator == $past(acc_exp))
    else $error("accumulator sum wrong");

  cover property ($rose(sleep_state));
  cover property ($fell(sleep_state));
  cover property (charge_accumulator == ACCUM_MAX);
endmodule

bind bms_seq bms_seq_checker #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_bms_seq_checker (.sys_clk, .rst_n, .sda_pull_req,
  .sleep_permit, .divider_supply_disable, .curr_adc_data, .sda_out, .sda_oe_n, .divider_supply_out, .volt_chan_sel,
  .curr_conv_run, .sleep_state, .bus_filt, .current_reg, .charge_accumulator);
`default_nettype wire
